// file: include/ifeb_pkg.sv
// ----------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------
package ifeb_pkg;

  localparam int          IFEB_ADDR_W   = 4;
  localparam int          IFEB_REG_W    = 16;
  localparam int          IFEB_DATA_W   = 32;

  // Byte addresses of the registers
  localparam logic [3:0]  ADDR_FLAG_FOUR = 4'h0;
  localparam logic [3:0]  ADDR_EN_ZERO   = 4'h4;
  localparam logic [3:0]  ADDR_EN_ONE    = 4'h8;
  localparam logic [3:0]  ADDR_EN_FOUR   = 4'hC;

  // Implemented bits; all others read zero and ignore writes
  localparam logic [15:0] MASK_FLAG_FOUR = 16'h00F6;
  localparam logic [15:0] MASK_EN_ZERO   = 16'h7FFF;
  localparam logic [15:0] MASK_EN_ONE    = 16'hFFFB;
  localparam logic [15:0] MASK_EN_FOUR   = 16'h00F6;
  localparam logic [15:0] RESET_VALUE    = 16'h0000;

  // Flag and paired enable positions of the fourth bank
  localparam int CAN2_TX_REQUEST_FLAG = 7;
  localparam int CAN1_TX_REQUEST_FLAG = 6;
  localparam int DMA_CH7_DONE_FLAG    = 5;
  localparam int DMA_CH6_DONE_FLAG    = 4;
  localparam int UART2_ERROR_FLAG     = 2;
  localparam int UART1_ERROR_FLAG     = 1;

  // Enable bank zero positions
  localparam int DMA_CH1_DONE_ENABLE       = 14;
  localparam int ADC_FIRST_DONE_ENABLE     = 13;
  localparam int UART1_TRANSMIT_ENABLE_IRQ = 12;
  localparam int UART1_RECEIVE_ENABLE_IRQ  = 11;
  localparam int SPI1_EVENT_ENABLE_IRQ     = 10;
  localparam int SPI1_ERROR_ENABLE_IRQ     = 9;
  localparam int TIMER3_ENABLE_IRQ         = 8;
  localparam int TIMER2_ENABLE_IRQ         = 7;
  localparam int EXTERNAL_IRQ0_ENABLE      = 0;

  // Enable bank one positions
  localparam int UART2_TRANSMIT_ENABLE_IRQ = 15;
  localparam int EXTERNAL_IRQ2_ENABLE      = 13;
  localparam int DMA_CH2_DONE_ENABLE       = 8;
  localparam int IN_CAPTURE8_ENABLE_IRQ    = 7;
  localparam int ADC_SECOND_DONE_ENABLE    = 5;
  localparam int CHANGE_NOTIFY_ENABLE_IRQ  = 3;
  localparam int I2C1_SLAVE_EVENT_ENABLE   = 0;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Byte-lane merge of a write into a register, unimplemented bits held at zero
  function automatic logic [15:0] ifeb_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0]  strb,
    input logic [15:0] mask
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0])
    begin
      res[7:0] = new_val[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = new_val[15:8];
    end
    return res & mask;
  endfunction

endpackage

// file: test/ifeb_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Peripheral event sources and level flags seen by the bank
// ----------------------------------------------------------------
module ifeb_src_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Commands from the bench
  input  wire logic [5:0]  fire,
  input  wire logic [15:0] lvl_zero,
  input  wire logic [15:0] lvl_one,
  // Toward the bank
  output logic             can2_tx_event,
  output logic             can1_tx_event,
  output logic             dma_ch7_done_event,
  output logic             dma_ch6_done_event,
  output logic             uart2_error_event,
  output logic             uart1_error_event,
  output logic [15:0]      src_flag_zero,
  output logic [15:0]      src_flag_one
);
  logic [5:0] ev_reg;

  // Sources launch from a flop, as real peripherals do; a pulse lasts one cycle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ev_reg        <= 6'h00;
      src_flag_zero <= 16'h0000;
      src_flag_one  <= 16'h0000;
    end
    else
    begin
      ev_reg        <= fire;
      src_flag_zero <= lvl_zero;
      src_flag_one  <= lvl_one;
    end
  end

  // Command bit k drives the source whose flag sits at position 7,6,5,4,2,1
  assign can2_tx_event      = ev_reg[0];
  assign can1_tx_event      = ev_reg[1];
  assign dma_ch7_done_event = ev_reg[2];
  assign dma_ch6_done_event = ev_reg[3];
  assign uart2_error_event  = ev_reg[4];
  assign uart1_error_event  = ev_reg[5];
endmodule

// file: test/tb_irq_flag_enable_bank.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench with a register mirror
// ----------------------------------------------------------------
module tb_irq_flag_enable_bank;
  import ifeb_pkg::*;

  logic        clock, reset_n, ce;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ev_c2, ev_c1, ev_d7, ev_d6, ev_u2, ev_u1;
  logic [5:0]  fire;
  logic [15:0] lvl_zero, lvl_one, sf_zero, sf_one;
  logic [15:0] irq_req_zero, irq_req_one, irq_req_four;
  logic [15:0] mreg [4];
  int          miscompares, cmp_count;
  int          pos  [6] = '{7, 6, 5, 4, 2, 1};
  logic [15:0] msk  [4] = '{MASK_FLAG_FOUR, MASK_EN_ZERO, MASK_EN_ONE, MASK_EN_FOUR};

  ifeb_src_model ifeb_src_model_i (.clock(clock), .reset_n(reset_n), .fire(fire),
    .lvl_zero(lvl_zero), .lvl_one(lvl_one), .can2_tx_event(ev_c2), .can1_tx_event(ev_c1),
    .dma_ch7_done_event(ev_d7), .dma_ch6_done_event(ev_d6), .uart2_error_event(ev_u2),
    .uart1_error_event(ev_u1), .src_flag_zero(sf_zero), .src_flag_one(sf_one));

  ifeb_top ifeb_top_i (.clock(clock), .reset_n(reset_n), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .can2_tx_event(ev_c2),
    .can1_tx_event(ev_c1), .dma_ch7_done_event(ev_d7), .dma_ch6_done_event(ev_d6),
    .uart2_error_event(ev_u2), .uart1_error_event(ev_u1), .src_flag_zero(sf_zero),
    .src_flag_one(sf_one), .irq_req_zero(irq_req_zero), .irq_req_one(irq_req_one),
    .irq_req_four(irq_req_four));

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Write with byte strobes; the mirror merges only on an aligned address
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] s);
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {16'($urandom), d};
    s_axi_wstrb   <= {2'($urandom), s};
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
    if (a[1:0] == 2'h0)
    begin
      if (s[0]) mreg[a[3:2]][7:0] = d[7:0];
      if (s[1]) mreg[a[3:2]][15:8] = d[15:8];
      mreg[a[3:2]] = mreg[a[3:2]] & msk[a[3:2]];
    end
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, (a[1:0] == 2'h0) ? {16'h0000, mreg[a[3:2]]} : 32'h0);
    chk(s_axi_rresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
  endtask

  // Let registered requests settle, then compare all three gated outputs
  task automatic chk_irq();
    repeat (4) @(posedge clock);
    chk(irq_req_zero, sf_zero & mreg[1]);
    chk(irq_req_one, sf_one & mreg[2]);
    chk(irq_req_four, mreg[0] & mreg[3]);
  endtask

  // One-cycle event burst; lost while the clock enable is low
  task automatic pulse(input logic [5:0] f, input logic en);
    @(posedge clock);
    fire <= f;
    ce   <= en;
    @(posedge clock);
    fire <= 6'h00;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    for (int k = 0; k < 6; k++)
      if (f[k] && en) mreg[0][pos[k]] = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, fire, lvl_zero, lvl_one} = '0;
    ce = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    for (int i = 0; i < 4; i++) mreg[i] = RESET_VALUE;
    void'($urandom(32'h8a18));
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    // Reset values, then all ones to expose every reserved position
    for (int i = 0; i < 4; i++) rd(4'(i * 4));
    for (int i = 0; i < 4; i++)
    begin
      wr(4'(i * 4), 16'hFFFF, 2'b11);
      rd(4'(i * 4));
    end
    // Random values and strobes, back to back
    repeat (40)
    begin
      wr({2'($urandom), 2'b00}, 16'($urandom), 2'($urandom));
      rd({2'($urandom), 2'b00});
    end
    // Unaligned places are refused and change nothing
    wr(4'h6, 16'hFFFF, 2'b11);
    rd(4'h6);
    for (int i = 0; i < 4; i++) rd(4'(i * 4));
    // Each event source lands in its own flag, then software clears it
    wr(4'h0, 16'h0000, 2'b11);
    wr(4'hC, 16'hFFFF, 2'b11);
    for (int k = 0; k < 6; k++)
    begin
      pulse(6'(1 << k), 1'b1);
      rd(4'h0);
      chk_irq();
      wr(4'h0, 16'h0000, 2'b11);
      rd(4'h0);
      chk_irq();
    end
    // A DMA channel 7 completion on the commit edge of a clearing write must survive it
    fork
      wr(4'h0, 16'h0000, 2'b11);
      begin
        @(posedge clock);
        fire <= 6'h04;
        @(posedge clock);
        fire <= 6'h00;
      end
    join
    mreg[0][DMA_CH7_DONE_FLAG] = 1'b1;
    rd(4'h0);
    pulse(6'h3F, 1'b0);
    rd(4'h0);
    pulse(6'h3F, 1'b1);
    wr(4'hC, 16'h00A2, 2'b01);
    chk_irq();
    // Random source levels against random enables
    repeat (20)
    begin
      lvl_zero <= 16'($urandom);
      lvl_one  <= 16'($urandom);
      wr(4'h4, 16'($urandom), 2'b11);
      wr(4'h8, 16'($urandom), 2'b11);
      chk_irq();
    end
    results();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge clock);
    miscompares++;
    results();
  end
endmodule

// file: verilog/ifeb_gate.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Per-bit request gate with registered output
// ----------------------------------------------------------------
module ifeb_gate #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // Flag and enable levels
  input  wire logic [WIDTH-1:0] flag,
  input  wire logic [WIDTH-1:0] enable,
  // Gated requests
  output logic      [WIDTH-1:0] request
);
  import ifeb_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] req;
  } ifeb_gate_state_t;

  ifeb_gate_state_t s_reg;
  ifeb_gate_state_t s_next;
  logic [WIDTH-1:0] gated;

  // A source passes only while both its flag and its enable are set
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    assign gated[i] = flag[i] & enable[i];
  end

  // Next state
  always_comb
  begin
    s_next     = s_reg;
    s_next.req = gated;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign request = s_reg.req;

endmodule

// file: verilog/ifeb_top.sv
`timescale 1ns/1ps
// Function
// - Unimplemented bits read zero and ignore writes.
// - Implemented flag and enable bits are read/write and reset to zero.
// - A flag reads one once its source requested while the clock enable was high or software wrote a one, until software writes a zero.
// - Enable one passes the source request; enable zero blocks it.
// - Fourth flag bank: bit 7 second CAN, bit 6 first CAN transmit request.
// - Fourth flag bank: bit 5 DMA channel 7, bit 4 DMA channel 6 done.
// - Fourth flag bank: bit 2 second UART error, bit 1 first UART error.
// - Enable bank zero upper byte maps DMA1, ADC1, UART1, SPI1, timer 3.
// - Enable bank zero lower byte maps timers 1-2, compares, captures, DMA0, INT0.
// - Enable bank one upper byte maps UART2, INT2, timers 4-5, compares, DMA2.
// - Enable bank one lower byte maps captures 7-8, ADC2, INT1, change, I2C1.
// - Fourth enable bank uses the same positions as the fourth flag bank.
module ifeb_top (
  // Clock, reset and clock enable
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          ce,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ifeb_pkg::IFEB_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [ifeb_pkg::IFEB_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic      [1:0]                    s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [ifeb_pkg::IFEB_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic      [ifeb_pkg::IFEB_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  // Peripheral event pulses for the fourth flag bank
  input  wire logic                          can2_tx_event,
  input  wire logic                          can1_tx_event,
  input  wire logic                          dma_ch7_done_event,
  input  wire logic                          dma_ch6_done_event,
  input  wire logic                          uart2_error_event,
  input  wire logic                          uart1_error_event,
  // Flag levels of the sources behind enable banks zero and one
  input  wire logic [ifeb_pkg::IFEB_REG_W-1:0] src_flag_zero,
  input  wire logic [ifeb_pkg::IFEB_REG_W-1:0] src_flag_one,
  // Gated requests toward the core
  output logic      [ifeb_pkg::IFEB_REG_W-1:0] irq_req_zero,
  output logic      [ifeb_pkg::IFEB_REG_W-1:0] irq_req_one,
  output logic      [ifeb_pkg::IFEB_REG_W-1:0] irq_req_four
);
  import ifeb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]            flag4;
    logic [15:0]            en0;
    logic [15:0]            en1;
    logic [15:0]            en4;
    logic                   aw_got;
    logic [IFEB_ADDR_W-1:0] awaddr;
    logic                   w_got;
    logic [15:0]            wdata;
    logic [1:0]             wstrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } ifeb_state_t;

  ifeb_state_t s_reg;
  ifeb_state_t s_next;
  logic [15:0] events;
  logic        do_write;

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  // Events land on their documented flag positions
  always_comb
  begin
    events                       = RESET_VALUE;
    events[CAN2_TX_REQUEST_FLAG] = can2_tx_event;
    events[CAN1_TX_REQUEST_FLAG] = can1_tx_event;
    events[DMA_CH7_DONE_FLAG]    = dma_ch7_done_event;
    events[DMA_CH6_DONE_FLAG]    = dma_ch6_done_event;
    events[UART2_ERROR_FLAG]     = uart2_error_event;
    events[UART1_ERROR_FLAG]     = uart1_error_event;
  end

  // A write commits once both address and data are held and no answer is pending
  assign do_write = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;

    // Address and data are taken in either order and held until committed
    if (s_reg.awready && s_axi_awvalid)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata[15:0];
      s_next.wstrb = s_axi_wstrb[1:0];
    end

    // Register write; unmapped addresses answer with an error and change nothing
    if (do_write)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      case (s_reg.awaddr)
        ADDR_FLAG_FOUR:
          s_next.flag4 = ifeb_merge(s_reg.flag4, s_reg.wdata, s_reg.wstrb,
                                    MASK_FLAG_FOUR);
        ADDR_EN_ZERO:
          s_next.en0 = ifeb_merge(s_reg.en0, s_reg.wdata, s_reg.wstrb,
                                  MASK_EN_ZERO);
        ADDR_EN_ONE:
          s_next.en1 = ifeb_merge(s_reg.en1, s_reg.wdata, s_reg.wstrb,
                                  MASK_EN_ONE);
        ADDR_EN_FOUR:
          s_next.en4 = ifeb_merge(s_reg.en4, s_reg.wdata, s_reg.wstrb,
                                  MASK_EN_FOUR);
        default:
          s_next.bresp = RESP_SLVERR;
      endcase
    end

    // Events are applied after the write so a set beats a same-cycle clear
    s_next.flag4 = (s_next.flag4 | events) & MASK_FLAG_FOUR;

    // Write response retires on bready
    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end

    // Ready drops while a word is held so the master keeps its payload
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;

    // Read: register value sampled at the address handshake
    if (s_reg.arready && s_axi_arvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      case (s_axi_araddr)
        ADDR_FLAG_FOUR: s_next.rdata[15:0] = s_reg.flag4;
        ADDR_EN_ZERO:   s_next.rdata[15:0] = s_reg.en0;
        ADDR_EN_ONE:    s_next.rdata[15:0] = s_reg.en1;
        ADDR_EN_FOUR:   s_next.rdata[15:0] = s_reg.en4;
        default:        s_next.rresp       = RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = !s_next.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // All state holds while the clock enable is low; events then are not seen
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  // Bank zero sources keep their flags outside this block
  ifeb_gate #(
    .WIDTH (IFEB_REG_W)
  ) u_gate_zero (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .flag    (src_flag_zero),
    .enable  (s_reg.en0),
    .request (irq_req_zero)
  );

  // Bank one sources keep their flags outside this block
  ifeb_gate #(
    .WIDTH (IFEB_REG_W)
  ) u_gate_one (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .flag    (src_flag_one),
    .enable  (s_reg.en1),
    .request (irq_req_one)
  );

  // Bank four pairs the local flags with the same-position enables
  ifeb_gate #(
    .WIDTH (IFEB_REG_W)
  ) u_gate_four (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .flag    (s_reg.flag4),
    .enable  (s_reg.en4),
    .request (irq_req_four)
  );

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Unimplemented positions never hold a one
  a_unimpl_bits_zero: assert property (
    ((s_reg.flag4 & ~MASK_FLAG_FOUR) == 16'h0000) &&
    ((s_reg.en0 & ~MASK_EN_ZERO) == 16'h0000) &&
    ((s_reg.en1 & ~MASK_EN_ONE) == 16'h0000) &&
    ((s_reg.en4 & ~MASK_EN_FOUR) == 16'h0000))
    else $error("unimplemented bit set");

  // Full-word write to enable bank zero is stored, masked to its implemented bits
  a_enable_write_lands: assert property (
    ce && do_write && (s_reg.awaddr == ADDR_EN_ZERO) && (s_reg.wstrb == 2'h3)
    |=> (s_reg.en0 == ($past(s_reg.wdata) & MASK_EN_ZERO)))
    else $error("enable write not stored");

  // A flag falls only through a write to the flag register
  a_flag_sticky: assert property (
    ce && !(do_write && (s_reg.awaddr == ADDR_FLAG_FOUR))
    |=> ((s_reg.flag4 & $past(s_reg.flag4)) == $past(s_reg.flag4)))
    else $error("flag cleared without write");

  // Second CAN transmit request sets its flag next edge
  a_can_flag_set: assert property (
    ce && can2_tx_event |=> s_reg.flag4[CAN2_TX_REQUEST_FLAG])
    else $error("can2 request not flagged");

  // DMA channel 7 completion sets its flag even during a clearing write
  a_dma_set_wins: assert property (
    ce && dma_ch7_done_event && do_write && (s_reg.awaddr == ADDR_FLAG_FOUR)
    |=> s_reg.flag4[DMA_CH7_DONE_FLAG])
    else $error("dma7 event lost to clear");

  // First UART error sets its flag next edge
  a_uart_flag_set: assert property (
    ce && uart1_error_event |=> s_reg.flag4[UART1_ERROR_FLAG])
    else $error("uart1 error not flagged");

  // Bank four request follows flag and enable with one cycle of latency
  a_req_four_gate: assert property (
    ce |=> (irq_req_four == ($past(s_reg.flag4) & $past(s_reg.en4))))
    else $error("bank four request mismatch");

  // Cleared ADC1 enable blocks its request at the next edge
  a_adc1_blocked: assert property (
    ce && !s_reg.en0[ADC_FIRST_DONE_ENABLE] |=> !irq_req_zero[ADC_FIRST_DONE_ENABLE])
    else $error("adc1 request leaked");

  // External interrupt 0 passes when enabled and flagged
  a_int0_passes: assert property (
    ce && s_reg.en0[EXTERNAL_IRQ0_ENABLE] && src_flag_zero[EXTERNAL_IRQ0_ENABLE]
    |=> irq_req_zero[EXTERNAL_IRQ0_ENABLE])
    else $error("int0 request blocked");

  // UART2 transmit request passes when enabled and flagged
  a_uart2_passes: assert property (
    ce && s_reg.en1[UART2_TRANSMIT_ENABLE_IRQ] && src_flag_one[UART2_TRANSMIT_ENABLE_IRQ]
    |=> irq_req_one[UART2_TRANSMIT_ENABLE_IRQ])
    else $error("uart2 tx request blocked");

  // Change notification blocked when disabled
  a_change_blocked: assert property (
    ce && !s_reg.en1[CHANGE_NOTIFY_ENABLE_IRQ] |=> !irq_req_one[CHANGE_NOTIFY_ENABLE_IRQ])
    else $error("change request leaked");

  // CAN2 enable in bank four gates its own flag position
  a_can2_pair: assert property (
    ce && s_reg.flag4[CAN2_TX_REQUEST_FLAG] && s_reg.en4[CAN2_TX_REQUEST_FLAG]
    |=> irq_req_four[CAN2_TX_REQUEST_FLAG])
    else $error("can2 request not raised");

  // Every write is answered one edge after it commits
  a_write_answer: assert property (
    ce && do_write ##1 ce |-> s_axi_bvalid)
    else $error("write not answered");

endmodule
